// ### rtl/clc_blocks.v
// What this block does
// - two argument compares joined by logic operator
// - comparator output is only 1 or 0
// - operator codes equal through logical AND
// - unselected argument reads as zero
// - both condition operators reset to OR
// - combining operator takes OR, AND, XOR only
// - latch starts off, reset wins over set
// - latch holds state when both inputs off
// - set/reset sources use percent min/max thresholds
// - curve table has eleven points, ten segments
// - axis kind selects data or time mode
// - time mode restart after last point, optional
// - responses ignore, ramp, jump
// - point zero response fixed as jump
// - ignore drops point and all higher
// - x values non-decreasing, device relies on it
// - output range spans active y min to max
`include "clc_defs.vh"

module clc_blocks #(
  parameter MS_CYCLES = `CLC_MS_PERIOD_NS / `CLC_CLK_PERIOD_NS
) (
  input wire clk_sys,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [15:0] cmp_arg1a,
  input wire [15:0] cmp_arg1b,
  input wire [15:0] cmp_arg2a,
  input wire [15:0] cmp_arg2b,
  input wire [15:0] lat_set_in,
  input wire [15:0] lat_rst_in,
  input wire [15:0] crv_in,
  output reg cmp_out,
  output reg lat_out,
  output reg [15:0] crv_out,
  output reg [15:0] crv_min,
  output reg [15:0] crv_max
);
  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  reg [2:0] op1_r; // condition 1 operator
  reg [2:0] op2_r; // condition 2 operator
  reg [1:0] op3_r; // combining operator
  reg [3:0] use_r; // argument source selected
  reg [7:0] set_min_r, set_max_r, rst_min_r, rst_max_r; // percent thresholds
  reg [15:0] set_fs_r, rst_fs_r; // full scale of latch sources
  reg mode_r; // axis kind
  reg restart_r; // time mode cycle restart
  reg [15:0] px_r [0:10]; // point x
  reg [15:0] py_r [0:10]; // point y
  reg [1:0] pr_r [0:10]; // point response
  reg set_st_r, rst_st_r; // latch source states
  reg [15:0] elapsed_r; // elapsed ms
  reg [31:0] tick_r; // ms divider
  reg en_d_r; // enable last cycle
  integer i; // loop index, register writes only
  integer j; // loop index, packed views only
  integer k; // loop index, curve search only

  // merge write data by byte enables
  function [31:0] bmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer b;
    begin
      bmerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b])
          bmerge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // one argument compare
  function cond_eval;
    input [2:0] op;
    input [15:0] a;
    input [15:0] b;
    begin
      case (op)
        `CLC_OP_EQ: cond_eval = (a == b);
        `CLC_OP_NE: cond_eval = (a != b);
        `CLC_OP_GT: cond_eval = (a > b);
        `CLC_OP_GE: cond_eval = (a >= b);
        `CLC_OP_LT: cond_eval = (a < b);
        `CLC_OP_LE: cond_eval = (a <= b);
        `CLC_OP_OR: cond_eval = (a != 16'h0000) | (b != 16'h0000);
        default: cond_eval = (a != 16'h0000) & (b != 16'h0000);
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_go = req & wb_we_i & wb_ack_o; // write lands on the ack edge
  wire pt_hit = (wb_adr_i >= `CLC_PT_BASE) && (wb_adr_i <= `CLC_PT_LAST) && (wb_adr_i[1:0] == 2'h0);
  wire [7:0] pt_off = wb_adr_i - `CLC_PT_BASE; // byte offset into point window
  wire [3:0] pt_idx = pt_off[5:2]; // point index, one word per point
  reg [31:0] cmp_word, resp_word, rd_nxt;
  wire [31:0] cmp_new = bmerge(cmp_word, wb_dat_i, wb_sel_i);
  wire [31:0] wr_new_set = bmerge({16'h0000, set_max_r, set_min_r}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_new_rst = bmerge({16'h0000, rst_max_r, rst_min_r}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_new_fs = bmerge({rst_fs_r, set_fs_r}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_new_pt = bmerge({py_r[pt_idx], px_r[pt_idx]}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_new_rsp = bmerge(resp_word, wb_dat_i, wb_sel_i);

  // packed views of registers
  always @* begin
    cmp_word = 32'h0000_0000;
    cmp_word[`CLC_OP1_LSB +: 3] = op1_r;
    cmp_word[`CLC_OP2_LSB +: 3] = op2_r;
    cmp_word[`CLC_OP3_LSB +: 2] = op3_r;
    cmp_word[`CLC_USE_LSB +: 4] = use_r;
    resp_word = 32'h0000_0000;
    for (j = 0; j < 11; j = j + 1)
      resp_word[2*j +: 2] = pr_r[j];
  end

  // read mux, unmapped reads zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (pt_hit)
      rd_nxt = {py_r[pt_idx], px_r[pt_idx]};
    else begin
      case (wb_adr_i)
        `CLC_CMP_CTRL: rd_nxt = cmp_word;
        `CLC_SET_THR: rd_nxt = {16'h0000, set_max_r, set_min_r};
        `CLC_RST_THR: rd_nxt = {16'h0000, rst_max_r, rst_min_r};
        `CLC_LAT_FS: rd_nxt = {rst_fs_r, set_fs_r};
        `CLC_CRV_CTRL: rd_nxt = {30'h0000_0000, restart_r, mode_r};
        `CLC_STATUS: rd_nxt = {crv_out, 12'h000, rst_st_r, set_st_r, lat_out, cmp_out};
        `CLC_CRV_RANGE: rd_nxt = {crv_max, crv_min};
        `CLC_ELAPSED: rd_nxt = {16'h0000, elapsed_r};
        `CLC_RESP: rd_nxt = resp_word;
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ack one cycle after request, dropped the cycle after
  always @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o)
        wb_dat_o <= rd_nxt;
    end
  end

  // register writes
  always @(posedge clk_sys) begin
    if (rst) begin
      op1_r <= `CLC_OP_OR;
      op2_r <= `CLC_OP_OR;
      op3_r <= `CLC_COMB_OR;
      use_r <= 4'h0;
      set_min_r <= `CLC_THR_MIN_RST;
      set_max_r <= `CLC_THR_MAX_RST;
      rst_min_r <= `CLC_THR_MIN_RST;
      rst_max_r <= `CLC_THR_MAX_RST;
      set_fs_r <= `CLC_FS_RST;
      rst_fs_r <= `CLC_FS_RST;
      mode_r <= `CLC_MODE_DATA;
      restart_r <= 1'b0;
      for (i = 0; i < 11; i = i + 1) begin
        px_r[i] <= 16'h0000;
        py_r[i] <= 16'h0000;
        pr_r[i] <= (i == 0) ? `CLC_RESP_JUMP : `CLC_RESP_IGNORE;
      end
    end else if (wr_go) begin
      if (pt_hit) begin
        px_r[pt_idx] <= wr_new_pt[15:0];
        py_r[pt_idx] <= wr_new_pt[31:16];
      end
      case (wb_adr_i)
        `CLC_CMP_CTRL: begin
          op1_r <= cmp_new[`CLC_OP1_LSB +: 3];
          op2_r <= cmp_new[`CLC_OP2_LSB +: 3];
          if (cmp_new[`CLC_OP3_LSB +: 2] != 2'h3)
            op3_r <= cmp_new[`CLC_OP3_LSB +: 2];
          use_r <= cmp_new[`CLC_USE_LSB +: 4];
        end
        `CLC_SET_THR: begin
          set_min_r <= wr_new_set[7:0];
          set_max_r <= wr_new_set[15:8];
        end
        `CLC_RST_THR: begin
          rst_min_r <= wr_new_rst[7:0];
          rst_max_r <= wr_new_rst[15:8];
        end
        `CLC_LAT_FS: begin
          set_fs_r <= wr_new_fs[15:0];
          rst_fs_r <= wr_new_fs[31:16];
        end
        `CLC_CRV_CTRL: begin
          mode_r <= wb_sel_i[0] ? wb_dat_i[0] : mode_r;
          restart_r <= wb_sel_i[0] ? wb_dat_i[1] : restart_r;
        end
        `CLC_RESP: begin
          for (i = 1; i < 11; i = i + 1)
            pr_r[i] <= wr_new_rsp[2*i +: 2];
        end
        default: ; // read-only or unmapped: ignored
      endcase
    end
  end

  // ---------------------------------------------------------------
  // comparator
  // ---------------------------------------------------------------
  wire [15:0] a1a = use_r[0] ? cmp_arg1a : 16'h0000;
  wire [15:0] a1b = use_r[1] ? cmp_arg1b : 16'h0000;
  wire [15:0] a2a = use_r[2] ? cmp_arg2a : 16'h0000;
  wire [15:0] a2b = use_r[3] ? cmp_arg2b : 16'h0000;
  wire c1 = cond_eval(op1_r, a1a, a1b);
  wire c2 = cond_eval(op2_r, a2a, a2b);
  reg comb_nxt;

  // combine the two conditions, single-bit result
  always @* begin
    case (op3_r)
      `CLC_COMB_AND: comb_nxt = c1 & c2;
      `CLC_COMB_XOR: comb_nxt = c1 ^ c2;
      default: comb_nxt = c1 | c2;
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst)
      cmp_out <= 1'b0;
    else
      cmp_out <= comb_nxt;
  end

  // ---------------------------------------------------------------
  // set/reset latch
  // ---------------------------------------------------------------
  // scaled compare: in*100 against threshold*full scale
  wire [23:0] set_pct = lat_set_in * `CLC_PCT_FULL;
  wire [23:0] rst_pct = lat_rst_in * `CLC_PCT_FULL;
  wire [23:0] set_hi = set_max_r * set_fs_r;
  wire [23:0] set_lo = set_min_r * set_fs_r;
  wire [23:0] rst_hi = rst_max_r * rst_fs_r;
  wire [23:0] rst_lo = rst_min_r * rst_fs_r;

  always @(posedge clk_sys) begin
    if (rst) begin
      set_st_r <= 1'b0;
      rst_st_r <= 1'b0;
      lat_out <= 1'b0;
    end else begin
      if (set_pct >= set_hi)
        set_st_r <= 1'b1;
      else if (set_pct <= set_lo)
        set_st_r <= 1'b0;
      if (rst_pct >= rst_hi)
        rst_st_r <= 1'b1;
      else if (rst_pct <= rst_lo)
        rst_st_r <= 1'b0;
      if (rst_st_r)
        lat_out <= 1'b0;
      else if (set_st_r)
        lat_out <= 1'b1;
      // both off: hold
    end
  end

  // ---------------------------------------------------------------
  // curve table
  // ---------------------------------------------------------------
  reg [3:0] last_idx; // highest active point
  reg alive;
  reg [3:0] seg; // segment end point
  reg found;
  reg [15:0] xin, y_nxt, mn_nxt, mx_nxt, span, off, yp, yi;
  reg [31:0] prod;
  wire en_in = (crv_in != 16'h0000);

  always @* begin
    last_idx = 4'h0;
    alive = 1'b1;
    mn_nxt = py_r[0];
    mx_nxt = py_r[0];
    for (k = 1; k < 11; k = k + 1) begin
      if (pr_r[k] == `CLC_RESP_IGNORE)
        alive = 1'b0;
      if (alive) begin
        last_idx = k[3:0];
        if (py_r[k] < mn_nxt) mn_nxt = py_r[k];
        if (py_r[k] > mx_nxt) mx_nxt = py_r[k];
      end
    end
    xin = (mode_r == `CLC_MODE_TIME) ? elapsed_r : crv_in;
    seg = 4'h0;
    found = 1'b0;
    for (k = 1; k < 11; k = k + 1) begin
      if (!found && (k <= last_idx) && (xin <= px_r[k])) begin
        seg = k[3:0];
        found = 1'b1;
      end
    end
    if (!found)
      seg = last_idx;
    yp = py_r[(seg == 4'h0) ? 4'h0 : seg - 4'h1];
    yi = py_r[seg];
    span = px_r[seg] - px_r[(seg == 4'h0) ? 4'h0 : seg - 4'h1];
    off = xin - px_r[(seg == 4'h0) ? 4'h0 : seg - 4'h1];
    prod = 32'h0000_0000;
    // point 0 and the region above the last active point is a jump
    if (seg == 4'h0 || !found || pr_r[seg] == `CLC_RESP_JUMP || span == 16'h0000)
      y_nxt = yi;
    else if (xin <= px_r[seg - 4'h1])
      y_nxt = yp;
    else if (yi >= yp) begin
      prod = (yi - yp) * off / span;
      y_nxt = yp + prod[15:0];
    end else begin
      prod = (yp - yi) * off / span;
      y_nxt = yp - prod[15:0];
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      crv_out <= 16'h0000;
      crv_min <= 16'h0000;
      crv_max <= 16'h0000;
    end else begin
      crv_out <= y_nxt;
      crv_min <= mn_nxt;
      crv_max <= mx_nxt;
    end
  end

  // ---------------------------------------------------------------
  // time mode elapsed counter
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      elapsed_r <= 16'h0000;
      tick_r <= 32'h0000_0000;
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= en_in;
      if (en_in & ~en_d_r) begin
        elapsed_r <= 16'h0000;
        tick_r <= 32'h0000_0000;
      end else if (en_in && mode_r == `CLC_MODE_TIME) begin
        if (tick_r == MS_CYCLES - 1) begin
          tick_r <= 32'h0000_0000;
          if (elapsed_r >= px_r[last_idx]) begin
            if (restart_r)
              elapsed_r <= 16'h0000;
          end else
            elapsed_r <= elapsed_r + 16'h0001;
        end else
          tick_r <= tick_r + 32'h0000_0001;
      end
      // enable inactive: elapsed time frozen
    end
  end
endmodule // clc_blocks

// ### rtl/clc_defs.vh
`ifndef CLC_DEFS_VH
`define CLC_DEFS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CLC_CMP_CTRL 8'h00
`define CLC_SET_THR 8'h04
`define CLC_RST_THR 8'h08
`define CLC_LAT_FS 8'h0C
`define CLC_CRV_CTRL 8'h10
`define CLC_STATUS 8'h14
`define CLC_CRV_RANGE 8'h18
`define CLC_ELAPSED 8'h1C
`define CLC_PT_BASE 8'h40
`define CLC_PT_LAST 8'h68
`define CLC_RESP 8'h80
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CLC_OP1_LSB 0
`define CLC_OP2_LSB 4
`define CLC_OP3_LSB 8
`define CLC_USE_LSB 12
// ---------------------------------------------------------------
// codes and reset values
// ---------------------------------------------------------------
`define CLC_OP_EQ 3'h0
`define CLC_OP_NE 3'h1
`define CLC_OP_GT 3'h2
`define CLC_OP_GE 3'h3
`define CLC_OP_LT 3'h4
`define CLC_OP_LE 3'h5
`define CLC_OP_OR 3'h6
`define CLC_OP_AND 3'h7
`define CLC_COMB_OR 2'h0
`define CLC_COMB_AND 2'h1
`define CLC_COMB_XOR 2'h2
`define CLC_RESP_IGNORE 2'h0
`define CLC_RESP_RAMP 2'h1
`define CLC_RESP_JUMP 2'h2
`define CLC_MODE_DATA 1'h0
`define CLC_MODE_TIME 1'h1
`define CLC_THR_MIN_RST 8'h19
`define CLC_THR_MAX_RST 8'h4B
`define CLC_FS_RST 16'hFFFF
`define CLC_PCT_FULL 8'h64
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLC_CLK_PERIOD_NS 4
`define CLC_MS_PERIOD_NS 1000000
`endif

// ### tb/clc_src_model.sv
// neighbour function blocks feeding the argument, latch and curve inputs
module clc_src_model (
  input wire logic clk_sys,
  input wire logic [15:0] val [7],
  output logic [15:0] src [7]
);
  timeunit 1ns;
  timeprecision 1ps;
  // known values before the first edge
  initial src = '{default: 16'h0};
  // a neighbour's output is registered, so requests land one clock later
  always @(posedge clk_sys) begin
    src <= val;
  end
endmodule // clc_src_model

// ### tb/clc_blocks_props.sv
module clc_blocks_props (
  input wire clk_sys,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [15:0] lat_set_in,
  input wire [15:0] lat_rst_in,
  input wire lat_out,
  input wire [15:0] crv_out,
  input wire [15:0] crv_min,
  input wire [15:0] crv_max
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_set_full;
    (lat_set_in == 16'hFFFF && lat_rst_in == 16'h0)[*2];
  endsequence
  sequence s_rst_full;
    (lat_rst_in == 16'hFFFF)[*2];
  endsequence
  sequence s_both_low;
    (lat_set_in == 16'h0 && lat_rst_in == 16'h0)[*3];
  endsequence
  sequence s_quiet;
    (!wb_cyc_i)[*2];
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_ack_one_late: assert property (s_req |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_no_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_latch_set_on: assert property (s_set_full |=> lat_out)
    else $error("latch did not turn on");
  a_latch_rst_wins: assert property (s_rst_full |=> !lat_out)
    else $error("latch on while reset source full");
  a_latch_holds: assert property (s_both_low |=> $stable(lat_out))
    else $error("latch changed with both sources off");
  a_crv_range_order: assert property (crv_min <= crv_max)
    else $error("curve min above max");
  a_crv_in_range: assert property (s_quiet |-> crv_out >= crv_min && crv_out <= crv_max)
    else $error("curve output outside range");
endmodule // clc_blocks_props

bind clc_blocks clc_blocks_props i_props (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .lat_set_in(lat_set_in), .lat_rst_in(lat_rst_in),
  .lat_out(lat_out), .crv_out(crv_out), .crv_min(crv_min), .crv_max(crv_max)
);

// ### tb/tb_clc_blocks.sv
module tb_clc_blocks;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [15:0] val [7] = '{default: 16'h0};
  logic [15:0] src [7];
  logic [15:0] lv [4];
  logic [63:0] expq [$];
  logic [63:0] ent;
  int px [11];
  int py [11];
  int pr [11];
  int num_errors = 0;
  int checks_done = 0;
  int seed = 59;
  int x;
  logic [2:0] o1, o2;
  logic [1:0] o3;
  logic [3:0] u;
  logic c1, c2, e;
  // latch steps: set source, reset source, expected {rst state, set state, latch}
  logic [35:0] lt [10] = '{36'hFFFF00006, 36'h000000002, 36'hBFFF00002, 36'hC00000006,
    36'hC000FFFFC, 36'h00008000_8, 36'hFFFF8000C, 36'hFFFF3FFF6, 36'h000040002,
    36'h0000FFFF8};

  clc_blocks #(.MS_CYCLES(4)) i_clc_blocks (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_arg1a(src[0]), .cmp_arg1b(src[1]),
    .cmp_arg2a(src[2]), .cmp_arg2b(src[3]), .lat_set_in(src[4]), .lat_rst_in(src[5]),
    .crv_in(src[6]), .cmp_out(), .lat_out(), .crv_out(), .crv_min(), .crv_max());
  clc_src_model i_clc_src_model (.clk_sys(clk_sys), .val(val), .src(src));

  initial forever #2 clk_sys = ~clk_sys;

  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // masked read-data compare
  task automatic chk(input logic [31:0] got, exp, msk);
    checks_done++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("Error at %0t: read %h expected %h", $time, got & msk, exp & msk);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    if (n >= 50) num_errors++;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, m);
    expq.push_back({m, ex});
    wb(1'h0, a, 32'h0);
  endtask
  // read monitor takes the oldest note
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
      if (expq.size() == 0) num_errors++;
      else begin
        ent = expq.pop_front();
        chk(wb_dat_o, ent[31:0], ent[63:32]);
      end
    end
  end
  function automatic logic cnd(input logic [2:0] op, input logic [15:0] a, b);
    case (op)
      3'h0: return a == b;
      3'h1: return a != b;
      3'h2: return a > b;
      3'h3: return a >= b;
      3'h4: return a < b;
      3'h5: return a <= b;
      3'h6: return a != 16'h0 || b != 16'h0;
      default: return a != 16'h0 && b != 16'h0;
    endcase
  endfunction
  function automatic int last_pt();
    int l = 0;
    for (int i = 1; i < 11 && pr[i] != 0; i++) l = i;
    return l;
  endfunction
  function automatic int crv(input int xi);
    int l = last_pt();
    if (xi <= px[0]) return py[0];
    for (int i = 1; i <= l; i++) begin
      if (xi <= px[i] && pr[i] == 2) return py[i];
      if (xi <= px[i]) return py[i-1] + (py[i] - py[i-1]) * (xi - px[i-1]) / (px[i] - px[i-1]);
    end
    return py[l];
  endfunction
  function automatic logic [31:0] rng();
    int lo = py[0];
    int hi = py[0];
    for (int i = 1; i <= last_pt(); i++) begin
      if (py[i] < lo) lo = py[i];
      if (py[i] > hi) hi = py[i];
    end
    return {hi[15:0], lo[15:0]};
  endfunction
  // points go highest index first
  task automatic ld_pts();
    logic [31:0] r = 32'h0;
    for (int i = 10; i >= 0; i--) begin
      wb(1'h1, 8'h40 + 8'(4 * i), {py[i][15:0], px[i][15:0]});
      r[2*i +: 2] = pr[i][1:0];
    end
    wb(1'h1, 8'h80, r);
  endtask
  task automatic crv_run();
    for (int k = 0; k < 12; k++) begin
      x = $random(seed) & 63;
      val[6] <= 16'(x);
      repeat (2) @(posedge clk_sys);
      rd(8'h14, 32'(crv(x)) << 16, 32'hFFFF0000);
    end
  endtask

  initial begin
    repeat (10000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    rd(8'h00, 32'h66, 32'hFFFFFFFF);
    wb(1'h1, 8'h80, 32'h0);
    rd(8'h80, 32'h2, 32'h3);
    rd(8'h30, 32'h0, 32'hFFFFFFFF);
    for (int k = 0; k < 48; k++) begin
      o1 = k[2:0];
      o2 = (k < 8) ? 3'h1 : 3'($random(seed));
      o3 = (k < 8) ? 2'h0 : 2'(k % 3);
      u = 4'($random(seed)) & ((k < 8) ? 4'h3 : 4'hF);
      for (int j = 0; j < 4; j++) begin
        lv[j] = 16'($random(seed) & 3);
        val[j] <= lv[j];
        if (!u[j]) lv[j] = 16'h0;
      end
      c1 = cnd(o1, lv[0], lv[1]);
      c2 = cnd(o2, lv[2], lv[3]);
      e = (o3 == 2'h0) ? (c1 | c2) : (o3 == 2'h1) ? (c1 & c2) : (c1 ^ c2);
      wb(1'h1, 8'h00, {16'h0, u, 2'h0, o3, 1'h0, o2, 1'h0, o1});
      rd(8'h14, {31'h0, e}, 32'h1);
    end
    for (int k = 0; k < 10; k++) begin
      val[4] <= lt[k][35:20];
      val[5] <= lt[k][19:4];
      repeat (3) @(posedge clk_sys);
      rd(8'h14, {28'h0, lt[k][3:0]}, 32'hE);
    end
    px = '{0, 10, 20, 40, 40, 40, 40, 40, 40, 40, 40};
    py = '{0: 100, 1: 200, 2: 50, 3: 250, default: 65535};
    pr = '{0: 2, 1: 1, 2: 2, 3: 1, default: 0};
    ld_pts();
    rd(8'h18, rng(), 32'hFFFFFFFF);
    crv_run();
    pr[2] = 0;
    ld_pts();
    rd(8'h18, rng(), 32'hFFFFFFFF);
    crv_run();
    px[1] = 4;
    py[0] = 0;
    py[1] = 40;
    ld_pts();
    val[6] <= 16'h0;
    wb(1'h1, 8'h10, 32'h1);
    val[6] <= 16'h1;
    repeat (80) @(posedge clk_sys);
    rd(8'h1C, 32'h4, 32'hFFFF);
    rd(8'h14, 32'h00280000, 32'hFFFF0000);
    val[6] <= 16'h0;
    repeat (4) @(posedge clk_sys);
    val[6] <= 16'h1;
    repeat (2) @(posedge clk_sys);
    rd(8'h1C, 32'h0, 32'hFFFF);
    end_sim();
  end
endmodule // tb_clc_blocks
